// [src/irq_controller.sv]
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
// Behaviour
// - Twelve interrupt sources plus the watchdog are arbitrated across three levels.
// - The supply interrupt alone sits at the fixed top level.
// - A pending supply interrupt preempts any running low- or high-tier routine.
// - A high-tier request preempts a routine running at the low tier.
// - When tiers collide in one cycle the high tier is granted first.
// - A request never preempts a routine of its own level.
// - Same-level requests resolve in the fixed polling order, supply first, second UART last.
// - Bit 7 of the enable register gates every source.
// - The enable register holds the per-source enables of the classic sources.
// - The priority register holds one tier bit per classic source, 1 meaning high.
// - Enable and priority registers can be changed one bit at a time; the extension cannot.
// - Reset loads 0x00, 0x00, 0xA0 and 0x10 into the four registers.
// - The tier of each source except the supply and the watchdog (fixed low) comes from the priority and extension registers together.
// - The extension register holds the remaining enables and tier bits.
// - Wake-up events are latched apart while the core is off; requests act only when it runs.
// - An external wake-up leaves an external interrupt pending until it is serviced.
module irq_controller
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt sources in polling order
    input  wire logic [12:0] irq_src,
    input  wire logic        wdt_timeout,
    // Wake-up events from the core-off sleep mode
    input  wire logic        wake_ext0,
    input  wire logic        wake_ext1,
    // Processor core
    input  wire logic        core_running,
    input  wire logic        irq_ack,
    input  wire logic        irq_reti,
    output logic             irq_req,
    output logic      [3:0]  irq_vector,
    output logic      [1:0]  irq_level
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0]  en_ff;
    logic [7:0]  ext_ff;
    logic [7:0]  pr_ff;
    logic [7:0]  wdc_ff;
    logic [1:0]  wake_pend_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        irq_req_ff;
    logic [3:0]  irq_vector_ff;
    logic [1:0]  irq_level_ff;

    logic        setup;
    logic        wr_commit;
    logic        mapped;
    logic [7:0]  wr_byte;
    logic [7:0]  bit_addr;
    logic        bit_val;
    logic        bit_wr;
    logic        bit_en;
    logic        bit_pr;
    src_vec_type src_en;
    src_vec_type src_prio;
    src_vec_type pend;
    src_vec_type high_pend;
    src_vec_type low_pend;
    logic        grant_valid;
    src_idx_type grant_idx;
    level_type   grant_level;
    level_type   cur_level;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    // Setup phase samples the read data; access phase commits the write
    assign setup     = psel && !penable;
    assign wr_commit = psel && penable && pready_ff && pwrite;
    assign wr_byte   = pwdata[7:0];
    assign bit_addr  = pwdata[7:0];
    assign bit_val   = pwdata[`IRQ_BIT_VAL_POS];
    assign bit_wr    = wr_commit && paddr == `IRQ_ADDR(`IRQ_BIT_IDX);
    // Only the enable and priority windows accept bit writes
    assign bit_en    = bit_wr && bit_addr[7:3] == 5'(`IRQ_EN_BIT_BASE >> 3);
    assign bit_pr    = bit_wr && bit_addr[7:3] == 5'(`IRQ_PR_BIT_BASE >> 3);

    // Read mux; unmapped addresses read zero and flag an error
    always_comb begin
        rd_word = 32'h0000_0000;
        mapped  = 1'b1;
        case (paddr)
            `IRQ_ADDR(`IRQ_EN_IDX):   rd_word[7:0] = en_ff;
            `IRQ_ADDR(`IRQ_EXT_IDX):  rd_word[7:0] = ext_ff;
            `IRQ_ADDR(`IRQ_PR_IDX):   rd_word[7:0] = pr_ff;
            `IRQ_ADDR(`IRQ_WDC_IDX):  rd_word[7:0] = wdc_ff;
            `IRQ_ADDR(`IRQ_BIT_IDX):  rd_word      = 32'h0000_0000;
            `IRQ_ADDR(`IRQ_STAT_IDX): rd_word[11:0] = {wake_pend_ff, cur_level, irq_level_ff,
                                                      irq_req_ff, 1'b0, irq_vector_ff};
            default:                  mapped = 1'b0;
        endcase
    end

    // One wait-free access phase: pready rises the cycle after setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata_ff <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Enable register, by byte or by single bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_ff <= `IRQ_EN_RST;
        end else if (wr_commit && paddr == `IRQ_ADDR(`IRQ_EN_IDX)) begin
            en_ff <= wr_byte;
        end else if (bit_en) begin
            en_ff[bit_addr[2:0]] <= bit_val;
        end
    end

    // Priority register, by byte or by single bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pr_ff <= `IRQ_PR_RST;
        end else if (wr_commit && paddr == `IRQ_ADDR(`IRQ_PR_IDX)) begin
            pr_ff <= wr_byte;
        end else if (bit_pr) begin
            pr_ff[bit_addr[2:0]] <= bit_val;
        end
    end

    // Extension register, whole byte only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_ff <= `IRQ_EXT_RST;
        end else if (wr_commit && paddr == `IRQ_ADDR(`IRQ_EXT_IDX)) begin
            ext_ff <= wr_byte;
        end
    end

    // Watchdog control; a timeout sets its flag even during a write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdc_ff <= `IRQ_WDC_RST;
        end else begin
            if (wr_commit && paddr == `IRQ_ADDR(`IRQ_WDC_IDX)) begin
                wdc_ff <= wr_byte;
            end
            if (wdt_timeout) begin
                wdc_ff[`IRQ_WDC_TO_POS] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Source mapping

    // Enable and tier per source, in polling order; the watchdog has no bits of its own
    assign src_en = {ext_ff[5], en_ff[5], en_ff[4], ext_ff[0], en_ff[3], en_ff[2],
                     en_ff[1], en_ff[0], en_ff[6], 1'b1, ext_ff[3], ext_ff[2],
                     ext_ff[`IRQ_SUPPLY_EN_POS]};
    assign src_prio = {ext_ff[7], pr_ff[5], pr_ff[4], ext_ff[4], pr_ff[3], pr_ff[2],
                       pr_ff[1], pr_ff[0], pr_ff[6], 1'b0, pr_ff[7], ext_ff[6],
                       1'b0};

    // Wake-ups are folded into the external requests only once the core runs
    always_comb begin
        pend = irq_src;
        pend[`IRQ_SRC_EXT0] = irq_src[`IRQ_SRC_EXT0] | wake_pend_ff[0];
        pend[`IRQ_SRC_EXT1] = irq_src[`IRQ_SRC_EXT1] | wake_pend_ff[1];
        pend = pend & src_en & {13{en_ff[`IRQ_GLOBAL_POS] && core_running}};
    end

    assign high_pend = pend & src_prio & 13'h1FFE;
    assign low_pend  = pend & ~src_prio & 13'h1FFE;

    ////////////////////////////////////////////////////////////////////////////////
    // Wake-up latch

    // Latched while the core is off; cleared when its vector is taken, set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_pend_ff <= 2'h0;
        end else begin
            if (irq_ack && irq_req_ff && irq_vector_ff == `IRQ_SRC_EXT0) begin
                wake_pend_ff[0] <= 1'b0;
            end
            if (irq_ack && irq_req_ff && irq_vector_ff == `IRQ_SRC_EXT1) begin
                wake_pend_ff[1] <= 1'b0;
            end
            if (wake_ext0 && !core_running) begin
                wake_pend_ff[0] <= 1'b1;
            end
            if (wake_ext1 && !core_running) begin
                wake_pend_ff[1] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Arbitration and core request

    irq_arbiter u_arbiter (
        .req         (pend),
        .prio        (src_prio),
        .cur_level   (cur_level),
        .grant_valid (grant_valid),
        .grant_idx   (grant_idx),
        .grant_level (grant_level)
    );

    // The level is pushed from the registered request the core saw
    irq_level_tracker u_tracker (
        .clk        (clk),
        .rst_n      (rst_n),
        .push       (irq_ack && irq_req_ff),
        .push_level (irq_level_ff),
        .pop        (irq_reti),
        .cur_level  (cur_level)
    );

    // Request registered each cycle; dropped while the ack is seen to avoid a double take
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req_ff    <= 1'b0;
            irq_vector_ff <= 4'h0;
            irq_level_ff  <= 2'h0;
        end else begin
            irq_req_ff    <= grant_valid && !irq_ack;
            irq_vector_ff <= grant_idx;
            irq_level_ff  <= grant_level;
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign irq_req    = irq_req_ff;
    assign irq_vector = irq_vector_ff;
    assign irq_level  = irq_level_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_global_off;
        @(posedge clk) disable iff (!rst_n)
        !en_ff[`IRQ_GLOBAL_POS] |=> !irq_req_ff;
    endproperty
    a_global_off: assert property (p_global_off) else $error("request with global enable off");

    property p_sleep_quiet;
        @(posedge clk) disable iff (!rst_n)
        !core_running |=> !irq_req_ff;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("request while core is off");

    property p_supply_first;
        @(posedge clk) disable iff (!rst_n)
        core_running && irq_src[0] && ext_ff[`IRQ_SUPPLY_EN_POS] && en_ff[`IRQ_GLOBAL_POS]
            && cur_level != 2'h3 && !irq_ack |=> irq_req_ff && irq_vector_ff == 4'h0
            && irq_level_ff == 2'h3;
    endproperty
    a_supply_first: assert property (p_supply_first) else $error("supply not granted at top");

    property p_supply_alone;
        @(posedge clk) disable iff (!rst_n)
        irq_level_ff == 2'h3 |-> irq_vector_ff == 4'h0;
    endproperty
    a_supply_alone: assert property (p_supply_alone) else $error("other source at top level");

    property p_no_same_level;
        @(posedge clk) disable iff (!rst_n)
        irq_req_ff |-> irq_level_ff > $past(cur_level);
    endproperty
    a_no_same_level: assert property (p_no_same_level) else $error("equal level preempted");

    property p_high_before_low;
        @(posedge clk) disable iff (!rst_n)
        irq_req_ff && irq_level_ff == 2'h1 |-> $past(high_pend) == 13'h0000;
    endproperty
    a_high_before_low: assert property (p_high_before_low) else $error("low tier won over high");

    property p_poll_order;
        @(posedge clk) disable iff (!rst_n)
        irq_req_ff && irq_level_ff == 2'h1
            |-> ($past(low_pend) & lower_mask(irq_vector_ff)) == 13'h0000;
    endproperty
    a_poll_order: assert property (p_poll_order) else $error("polling order broken");

    property p_ext_not_bitwise;
        @(posedge clk) disable iff (!rst_n)
        bit_wr |=> $stable(ext_ff);
    endproperty
    a_ext_not_bitwise: assert property (p_ext_not_bitwise) else $error("bit write hit extension");

    property p_bit_set_global;
        @(posedge clk) disable iff (!rst_n)
        bit_wr && bit_addr == 8'hAF |=> en_ff[7] == $past(bit_val);
    endproperty
    a_bit_set_global: assert property (p_bit_set_global) else $error("bit write to enable lost");

    property p_ext_write;
        @(posedge clk) disable iff (!rst_n)
        wr_commit && paddr == `IRQ_ADDR(`IRQ_EXT_IDX) |=> ext_ff == $past(pwdata[7:0]);
    endproperty
    a_ext_write: assert property (p_ext_write) else $error("extension write lost");

    property p_wake_latch;
        @(posedge clk) disable iff (!rst_n)
        wake_ext0 && !core_running |=> wake_pend_ff[0] [*2];
    endproperty
    a_wake_latch: assert property (p_wake_latch) else $error("wake-up not held pending");

    c_preempt_low: cover property (@(posedge clk) disable iff (!rst_n)
        cur_level == 2'h1 && irq_req_ff && irq_level_ff == 2'h2);
    c_supply_over_high: cover property (@(posedge clk) disable iff (!rst_n)
        cur_level == 2'h2 && irq_req_ff && irq_level_ff == 2'h3);
    c_wake_vector: cover property (@(posedge clk) disable iff (!rst_n)
        irq_ack && irq_req_ff && irq_vector_ff == 4'h5 && wake_pend_ff[0]);
endmodule

// [src/irq_ctrl_regs.svh]
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// Register indices; the byte address is four times the index
`define IRQ_EN_IDX        8'hA8
`define IRQ_EXT_IDX       8'hA9
`define IRQ_PR_IDX        8'hB8
`define IRQ_WDC_IDX       8'hC0
`define IRQ_BIT_IDX       8'hF0
`define IRQ_STAT_IDX      8'hF1
`define IRQ_ADDR(idx)     ({2'b00, idx, 2'b00})

// Bit-address windows of the bit-addressable registers
`define IRQ_EN_BIT_BASE   8'hA8
`define IRQ_PR_BIT_BASE   8'hB8
`define IRQ_BIT_VAL_POS   8

// Reset values
`define IRQ_EN_RST        8'h00
`define IRQ_EXT_RST       8'hA0
`define IRQ_PR_RST        8'h00
`define IRQ_WDC_RST       8'h10

// Field positions
`define IRQ_GLOBAL_POS    7
`define IRQ_SUPPLY_EN_POS 1
`define IRQ_WDC_TO_POS    2

// Source positions in polling order
`define IRQ_SRC_SUPPLY    4'h0
`define IRQ_SRC_EXT0      4'h5
`define IRQ_SRC_EXT1      4'h7
`define IRQ_NUM_SRC       13

`endif

// [src/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

    // Level of a routine in progress: 0 none, 1 low, 2 high, 3 supply
    typedef logic [1:0]  level_type;
    typedef logic [12:0] src_vec_type;
    typedef logic [3:0]  src_idx_type;

    // Lowest set index, that is the first in polling order
    function automatic src_idx_type first_set(input src_vec_type v);
        src_idx_type r;
        int          i;
        r = 4'h0;
        for (i = 12; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Mask of all positions polled before idx
    function automatic src_vec_type lower_mask(input src_idx_type idx);
        src_vec_type m;
        int          i;
        m = 13'h0000;
        for (i = 0; i < 13; i++) begin
            m[i] = (i < int'(idx));
        end
        return m;
    endfunction

endpackage

// [src/irq_arbiter.sv]
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
module irq_arbiter
    import irq_ctrl_pkg::*;
(
    // Requests
    input  wire src_vec_type req,
    input  wire src_vec_type prio,
    input  wire level_type   cur_level,
    // Winner
    output logic             grant_valid,
    output src_idx_type      grant_idx,
    output level_type        grant_level
);
    src_vec_type high_req;
    src_vec_type low_req;

    // Supply first, then high tier, then low tier
    always_comb begin
        high_req = req & prio & 13'h1FFE;
        low_req  = req & ~prio & 13'h1FFE;
        if (req[`IRQ_SRC_SUPPLY]) begin
            grant_idx   = `IRQ_SRC_SUPPLY;
            grant_level = 2'h3;
        end else if (|high_req) begin
            grant_idx   = first_set(high_req);
            grant_level = 2'h2;
        end else begin
            grant_idx   = first_set(low_req);
            grant_level = 2'h1;
        end
        // Only a strictly higher level may preempt
        grant_valid = (|req) && (grant_level > cur_level);
    end
endmodule

// [src/irq_level_tracker.sv]
`timescale 1ns/1ns
module irq_level_tracker
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst_n,
    // Core events
    input  wire logic      push,
    input  wire level_type push_level,
    input  wire logic      pop,
    // Level now in service
    output level_type      cur_level
);
    logic [2:0] active_ff;
    logic [2:0] nxt_active;
    logic [2:0] popped;

    // Return clears the highest level first, then a new entry is added
    always_comb begin
        popped = active_ff;
        if (pop) begin
            if (active_ff[2]) begin
                popped[2] = 1'b0;
            end else if (active_ff[1]) begin
                popped[1] = 1'b0;
            end else begin
                popped[0] = 1'b0;
            end
        end
        nxt_active = popped;
        if (push && push_level != 2'h0) begin
            nxt_active[push_level - 2'h1] = 1'b1;
        end
    end

    // Levels in progress
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_ff <= 3'h0;
        end else begin
            active_ff <= nxt_active;
        end
    end

    assign cur_level = active_ff[2] ? 2'h3 : active_ff[1] ? 2'h2 : active_ff[0] ? 2'h1 : 2'h0;

    property p_reti_pops;
        @(posedge clk) disable iff (!rst_n)
        pop && !push && active_ff == 3'h3 |=> active_ff == 3'h1;
    endproperty
    a_reti_pops: assert property (p_reti_pops) else $error("return did not restore level");
endmodule

// [verification/core_model.sv]
`timescale 1ns/1ns
module core_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Controller side
    input  wire logic irq_req,
    output logic      irq_ack,
    output logic      irq_reti,
    // Bench control
    input  wire logic ack_en,
    input  wire logic reti_go
);
    ////////////////////////////////////////////////////////////////////////////////
    // Take the presented request once; a held ack would double-push a level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= ack_en && irq_req && !irq_ack;
        end
    end

    // Return from a routine, one cycle wide
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reti <= 1'b0;
        end else begin
            irq_reti <= reti_go && !irq_reti;
        end
    end
endmodule

// [verification/three_level_irq_controller_tb.sv]
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
module three_level_irq_controller_tb;
    // Bench signals
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [12:0] src;
    logic        wake0;
    logic        core_running;
    logic        ack_en;
    logic        reti_go;
    logic        irq_ack;
    logic        irq_reti;
    logic        irq_req;
    logic [3:0]  irq_vector;
    logic [1:0]  irq_level;
    logic [31:0] rd;
    logic        er;
    int          num_errors;
    int          comparisons;

    ////////////////////////////////////////////////////////////////////////////////
    // Design and core model
    irq_controller u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_src(src), .wdt_timeout(1'b0), .wake_ext0(wake0),
        .wake_ext1(1'b0), .core_running(core_running), .irq_ack(irq_ack),
        .irq_reti(irq_reti), .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_level(irq_level));
    core_model u_core (.clk(clk), .rst_n(rst_n), .irq_req(irq_req), .irq_ack(irq_ack),
        .irq_reti(irq_reti), .ack_en(ack_en), .reti_go(reti_go));

    // Clock at 20 MHz
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // A wait that runs out is a failure and ends the run
    task automatic give_up();
        num_errors++;
        end_of_test();
    endtask

    // One APB transfer; waits on pready, never on a cycle count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) give_up();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expect a request to the core with this vector and level
    task automatic wait_req(input logic [3:0] v, input logic [1:0] l);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (irq_req === 1'b1) break;
        end
        if (i == 20) give_up();
        check({26'h0, irq_vector, irq_level}, {26'h0, v, l});
    endtask

    // Expect no request for n cycles
    task automatic no_req(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1;
            seen = seen | irq_req;
        end
        check({31'h0, seen}, 32'h0);
    endtask

    task automatic take();
        int i;
        @(posedge clk);
        ack_en <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (irq_ack === 1'b1) break;
        end
        if (i == 20) give_up();
        ack_en <= 1'b0;
    endtask

    task automatic ret();
        @(posedge clk);
        reti_go <= 1'b1;
        @(posedge clk);
        reti_go <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [11:0] ra [4];
        logic [7:0]  rv [4];
        ra = '{`IRQ_ADDR(`IRQ_EN_IDX), `IRQ_ADDR(`IRQ_EXT_IDX), `IRQ_ADDR(`IRQ_PR_IDX),
               `IRQ_ADDR(`IRQ_WDC_IDX)};
        rv = '{8'h00, 8'hA0, 8'h00, 8'h10};
        num_errors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        {psel, penable, pwrite, wake0, ack_en, reti_go} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        src = 13'h0000;
        core_running = 1'b1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then an unmapped place
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, ra[k], 32'h0);
            check(rd, {24'h0, rv[k]});
        end
        apb(1'b0, 12'h010, 32'h0);
        check({er, rd[30:0]}, 32'h8000_0000);
        // Enables set but global off: nothing reaches the core
        apb(1'b1, `IRQ_ADDR(`IRQ_EN_IDX), 32'h03);
        @(posedge clk) src <= 13'h0060;
        no_req(10);
        // Global on by bit access; same tier resolves by poll order
        apb(1'b1, `IRQ_ADDR(`IRQ_BIT_IDX), 32'h1AF);
        apb(1'b0, `IRQ_ADDR(`IRQ_EN_IDX), 32'h0);
        check(rd, 32'h83);
        wait_req(4'h5, 2'd1);
        // Timer 0 to high tier wins the collision
        apb(1'b1, `IRQ_ADDR(`IRQ_PR_IDX), 32'h02);
        apb(1'b0, `IRQ_ADDR(`IRQ_PR_IDX), 32'h0);
        check(rd, 32'h02);
        wait_req(4'h6, 2'd2);
        take();
        no_req(8);
        // Supply interrupt preempts a high routine
        apb(1'b1, `IRQ_ADDR(`IRQ_EXT_IDX), 32'hA2);
        apb(1'b0, `IRQ_ADDR(`IRQ_EXT_IDX), 32'h0);
        check(rd, 32'hA2);
        @(posedge clk) src[0] <= 1'b1;
        wait_req(4'h0, 2'd3);
        take();
        @(posedge clk) src <= 13'h0020;
        ret();
        no_req(8);
        ret();
        wait_req(4'h5, 2'd1);
        take();
        // High tier preempts a low routine
        @(posedge clk) src[6] <= 1'b1;
        wait_req(4'h6, 2'd2);
        take();
        @(posedge clk) src <= 13'h0000;
        ret();
        ret();
        // Core off: requests are held back, wake-up stays pending
        @(posedge clk) core_running <= 1'b0;
        @(posedge clk) src[6] <= 1'b1;
        no_req(8);
        @(posedge clk) wake0 <= 1'b1;
        @(posedge clk) wake0 <= 1'b0;
        src[6] <= 1'b0;
        @(posedge clk) core_running <= 1'b1;
        wait_req(4'h5, 2'd1);
        take();
        ret();
        end_of_test();
    end
endmodule
